// file: tocp_top.v
// Two output compare channels with one pulse mode on a 16-bit timer
`include "tocp_regs.vh"
module tocp_top (
   input  wire        pclk,         // Bus and CPU clock
   input  wire        presetn,      // Async reset, low
   input  wire        psel,         // APB select
   input  wire        penable,      // APB enable
   input  wire        pwrite,       // APB direction
   input  wire [7:0]  paddr,        // APB byte address
   input  wire [31:0] pwdata,       // APB write data
   output reg  [31:0] prdata,       // APB read data
   output reg         pready,       // APB ready
   output reg         pslverr,      // APB error
   input  wire        capture_in_pin1, // Capture input 1
   input  wire        capture_in_pin2, // Capture input 2
   input  wire        ext_clk_pin,  // External timer clock
   input  wire        gpio_out1,    // Port latch for pin 1 as I/O
   input  wire        gpio_out2,    // Port latch for pin 2 as I/O
   output reg         compare_out_pin1, // Pin 1 level
   output reg         compare_out_pin2, // Pin 2 level
   output reg         timer_irq     // Timer interrupt request
);
   reg  [7:0]  timer_control_1;
   reg  [7:0]  timer_control_2;
   reg         global_mask;
   reg  [15:0] compare_value_1;
   reg  [15:0] compare_value_2;
   reg  [15:0] capture1_value;
   reg  [15:0] capture2_value;
   reg  [15:0] counter;
   reg         compare1_flag;
   reg         compare2_flag;
   reg         capture1_flag;
   reg         capture2_flag;
   reg         cmp1_hold;
   reg         cmp2_hold;
   reg         cap1_armed;
   reg         cap2_armed;
   reg         cmp1_latch;
   reg         cmp2_latch;
   reg  [2:0]  presc;
   reg         ext_q;
   reg         cap1_q;
   reg         cap2_q;
   reg         tick;
   reg  [15:0] cnt_prev;

   wire        acc      = psel && penable;
   wire        wr       = acc && pwrite;
   wire        rd       = acc && !pwrite;
   wire        pwm_mode = timer_control_2[`TOCP_C2_PWM];
   wire        opm_mode = timer_control_2[`TOCP_C2_OPM] && !pwm_mode;
   wire [1:0]  csel     = {timer_control_2[`TOCP_C2_CSH], timer_control_2[`TOCP_C2_CSL]};
   wire        lvl1     = timer_control_1[`TOCP_C1_LVL1];
   wire        lvl2     = timer_control_1[`TOCP_C1_LVL2];
   wire        pin1e    = timer_control_2[`TOCP_C2_PIN1E];
   wire        pin2e    = timer_control_2[`TOCP_C2_PIN2E];

   // Edge select: 1 means rising
   function edge_seen;
      input prev;
      input cur;
      input rising;
      begin
         edge_seen = rising ? (!prev && cur) : (prev && !cur);
      end
   endfunction

   wire ext_edge = edge_seen(ext_q, ext_clk_pin, timer_control_2[`TOCP_C2_EXEDG]);
   wire cap1_edge = edge_seen(cap1_q, capture_in_pin1, timer_control_1[`TOCP_C1_EDGE1]);
   wire cap2_edge = edge_seen(cap2_q, capture_in_pin2, timer_control_2[`TOCP_C2_EDGE2]);

   // Prescaler enable: /2, /4, /8 or external edge
   reg next_tick;
   always @* begin
      case (csel)
         2'b00:   next_tick = (presc[0] == 1'b1);
         2'b01:   next_tick = (presc[1:0] == 2'b11);
         2'b10:   next_tick = (presc == 3'b111);
         default: next_tick = ext_edge;
      endcase
   end

   // Capture 1 restarts counter only in one pulse mode; PWM disconnects it
   wire opm_trig  = opm_mode && cap1_edge && cap1_armed;
   // Matches are evaluated on the count held through the timer cycle
   wire match1 = (counter == compare_value_1) && !cmp1_hold;
   wire match2 = (counter == compare_value_2) && !cmp2_hold;
   wire new_count = tick && (counter != cnt_prev);
   // Status read while set arms the clear; low byte access completes it
   wire st_rd   = rd && paddr == `TOCP_A_STATUS;
   wire oc1l_ac = acc && paddr == `TOCP_A_OC1L;
   wire oc2l_ac = acc && paddr == `TOCP_A_OC2L;
   wire ic1l_ac = acc && paddr == `TOCP_A_IC1L;
   wire ic2l_ac = acc && paddr == `TOCP_A_IC2L;

   // Counter and prescaler
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         counter  <= `TOCP_CNT_RST;
         cnt_prev <= 16'h0000;
         presc    <= 3'h0;
         tick     <= 1'b0;
         ext_q    <= 1'b0;
         cap1_q   <= 1'b0;
         cap2_q   <= 1'b0;
      end else begin
         ext_q    <= ext_clk_pin;
         cap1_q   <= capture_in_pin1;
         cap2_q   <= capture_in_pin2;
         presc    <= presc + 3'h1;
         tick     <= next_tick;
         cnt_prev <= counter;
         if (opm_trig || (wr && paddr == `TOCP_A_CNTL))
            counter <= `TOCP_CNT_RST;
         else if (next_tick)
            counter <= counter + 16'h0001;
      end
   end

   // Flags, captures, pins
   reg clr1_arm, clr2_arm, clrc1_arm, clrc2_arm;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         compare1_flag <= 1'b0;
         compare2_flag <= 1'b0;
         capture1_flag <= 1'b0;
         capture2_flag <= 1'b0;
         clr1_arm      <= 1'b0;
         clr2_arm      <= 1'b0;
         clrc1_arm     <= 1'b0;
         clrc2_arm     <= 1'b0;
         capture1_value <= 16'h0000;
         capture2_value <= 16'h0000;
         cmp1_latch    <= 1'b0;
         cmp2_latch    <= 1'b0;
      end else begin
         // Arming of the two-step clear
         if (st_rd) begin
            clr1_arm  <= compare1_flag;
            clr2_arm  <= compare2_flag;
            clrc1_arm <= capture1_flag;
            clrc2_arm <= capture2_flag;
         end
         // Set wins over clear for every flag
         if (match1 && new_count && !opm_mode && !pwm_mode)
            compare1_flag <= 1'b1;
         else if (oc1l_ac && clr1_arm) begin
            compare1_flag <= 1'b0;
            clr1_arm      <= 1'b0;
         end
         if (match2 && new_count && !pwm_mode)
            compare2_flag <= 1'b1;
         else if (oc2l_ac && clr2_arm) begin
            compare2_flag <= 1'b0;
            clr2_arm      <= 1'b0;
         end
         if ((cap1_edge && cap1_armed && !pwm_mode) || opm_trig) begin
            capture1_flag  <= 1'b1;
            capture1_value <= counter;
         end else if (ic1l_ac && clrc1_arm) begin
            capture1_flag <= 1'b0;
            clrc1_arm     <= 1'b0;
         end
         if (cap2_edge && cap2_armed) begin
            capture2_flag  <= 1'b1;
            capture2_value <= counter;
         end else if (ic2l_ac && clrc2_arm) begin
            capture2_flag <= 1'b0;
            clrc2_arm     <= 1'b0;
         end
         // Pin 1 latch
         if (opm_mode) begin
            if (opm_trig)
               cmp1_latch <= lvl2;
            else if (match1 && new_count)
               cmp1_latch <= lvl1;
         end else if (!pwm_mode) begin
            if (timer_control_1[`TOCP_C1_FORCE1])
               cmp1_latch <= lvl1;
            else if (match1 && new_count && pin1e)
               cmp1_latch <= lvl1;
         end
         // Pin 2 carries no waveform in one pulse mode
         if (!opm_mode && !pwm_mode) begin
            if (timer_control_1[`TOCP_C1_FORCE2])
               cmp2_latch <= lvl2;
            else if (match2 && new_count && pin2e)
               cmp2_latch <= lvl2;
         end
      end
   end

   // Registers and APB slave; single-cycle access, zero wait states
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_control_1 <= `TOCP_CTRL_RST;
         timer_control_2 <= `TOCP_CTRL_RST;
         global_mask     <= 1'b1;
         compare_value_1 <= `TOCP_CMP_RST;
         compare_value_2 <= `TOCP_CMP_RST;
         cmp1_hold  <= 1'b0;
         cmp2_hold  <= 1'b0;
         cap1_armed <= 1'b1;
         cap2_armed <= 1'b1;
         prdata     <= 32'h0000_0000;
         pready     <= 1'b0;
         pslverr    <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
         // Forcing is a one-shot request; bits self-clear
         timer_control_1[`TOCP_C1_FORCE1] <= 1'b0;
         timer_control_1[`TOCP_C1_FORCE2] <= 1'b0;
         if (psel && !penable) begin
            case (paddr)
               `TOCP_A_CTRL1:  prdata <= {24'h0, timer_control_1};
               `TOCP_A_CTRL2:  prdata <= {24'h0, timer_control_2};
               `TOCP_A_STATUS: prdata <= {24'h0, capture1_flag, compare1_flag, 1'b0,
                                          capture2_flag, compare2_flag, 3'h0};
               `TOCP_A_OC1H:   prdata <= {24'h0, compare_value_1[15:8]};
               `TOCP_A_OC1L:   prdata <= {24'h0, compare_value_1[7:0]};
               `TOCP_A_OC2H:   prdata <= {24'h0, compare_value_2[15:8]};
               `TOCP_A_OC2L:   prdata <= {24'h0, compare_value_2[7:0]};
               `TOCP_A_IC1H:   prdata <= {24'h0, capture1_value[15:8]};
               `TOCP_A_IC1L:   prdata <= {24'h0, capture1_value[7:0]};
               `TOCP_A_IC2H:   prdata <= {24'h0, capture2_value[15:8]};
               `TOCP_A_IC2L:   prdata <= {24'h0, capture2_value[7:0]};
               `TOCP_A_CNTH:   prdata <= {24'h0, counter[15:8]};
               `TOCP_A_CNTL:   prdata <= {24'h0, counter[7:0]};
               `TOCP_A_MASK:   prdata <= {31'h0, global_mask};
               default:        pslverr <= 1'b1;
            endcase
         end
         // Capture high byte read holds off capture until low byte read or write
         if (rd && paddr == `TOCP_A_IC1H) cap1_armed <= 1'b0;
         if (ic1l_ac) cap1_armed <= 1'b1;
         if (rd && paddr == `TOCP_A_IC2H) cap2_armed <= 1'b0;
         if (ic2l_ac) cap2_armed <= 1'b1;
         if (wr) begin
            case (paddr)
               `TOCP_A_CTRL1: timer_control_1 <= pwdata[7:0];
               `TOCP_A_CTRL2: timer_control_2 <= pwdata[7:0];
               `TOCP_A_OC1H: begin
                  compare_value_1[15:8] <= pwdata[7:0];
                  cmp1_hold <= 1'b1;
               end
               `TOCP_A_OC1L: begin
                  compare_value_1[7:0] <= pwdata[7:0];
                  cmp1_hold <= 1'b0;
               end
               `TOCP_A_OC2H: begin
                  compare_value_2[15:8] <= pwdata[7:0];
                  cmp2_hold <= 1'b1;
               end
               `TOCP_A_OC2L: begin
                  compare_value_2[7:0] <= pwdata[7:0];
                  cmp2_hold <= 1'b0;
               end
               `TOCP_A_MASK: global_mask <= pwdata[0];
               default: ;
            endcase
         end
      end
   end

   // Pins and interrupt; flags stay pending until enabled and unmasked
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         compare_out_pin1 <= 1'b0;
         compare_out_pin2 <= 1'b0;
         timer_irq        <= 1'b0;
      end else begin
         compare_out_pin1 <= pin1e ? cmp1_latch : gpio_out1;
         compare_out_pin2 <= pin2e ? cmp2_latch : gpio_out2;
         timer_irq <= !global_mask &&
            ((timer_control_1[`TOCP_C1_CMPIE] && (compare1_flag || compare2_flag)) ||
             (timer_control_1[`TOCP_C1_CAPIE] && (capture1_flag || capture2_flag)));
      end
   end
endmodule // tocp_top

// file: tocp_regs.vh
// Register map, field positions and reset values of the compare block
// Overview of operation
// - Each timer count, equal compare value sets channel flag and drives its level.
// - Interrupt on compare only if enable set and global mask clear.
// - Compare values read/write by software only; reset loads 8000h.
// - Compare output latches are low during reset.
// - Pin enable dedicates the output pin to the compare signal.
// - Pin enable clear: level not applied, interrupt still possible.
// - Flag clears after status read while set, then compare low byte access.
// - High byte write suspends compare until the low byte is written.
// - Flag and pin assert during the count equal to compare value.
// - Timer counts at clock/2, /4, /8 or external clock; one count resolution.
// - Force bit copies level to enabled pin without flag or interrupt.
// - Force bits are ignored in one pulse and PWM modes.
// - Single pulse select bit in control 2 enters one pulse mode.
// - Capture-1 edge: capture counter, reload FFFCh, drive level 2, set capture flag 1.
// - One pulse: counter equal compare 1 drives level 1, ending pulse.
// - Pulse lasts compare value 1 plus 5 counts.
// - One pulse mode never sets compare flag 1; flag 2 still interrupts.
// - PWM and single pulse both set means PWM mode only.
// - Equal levels in one pulse mode give a constant pin.
// - Capture 2 still works in one pulse mode; capture-1 edge resets counter.
// - Compare 2 flags timeouts in one pulse mode, no output waveform.
// - Counter is 16-bit free-running up, reset and reload value FFFCh.
// - Clock select both ones selects external clock.
// - Interrupt stays pending until enable and global mask allow it.
`ifndef TOCP_REGS_VH
`define TOCP_REGS_VH
`define TOCP_A_CTRL1    8'h00
`define TOCP_A_CTRL2    8'h04
`define TOCP_A_STATUS   8'h08
`define TOCP_A_OC1H     8'h0c
`define TOCP_A_OC1L     8'h10
`define TOCP_A_OC2H     8'h14
`define TOCP_A_OC2L     8'h18
`define TOCP_A_IC1H     8'h1c
`define TOCP_A_IC1L     8'h20
`define TOCP_A_IC2H     8'h24
`define TOCP_A_IC2L     8'h28
`define TOCP_A_CNTH     8'h2c
`define TOCP_A_CNTL     8'h30
`define TOCP_A_MASK     8'h34
// Control 1 bits
`define TOCP_C1_CAPIE   7
`define TOCP_C1_CMPIE   6
`define TOCP_C1_FORCE2  4
`define TOCP_C1_FORCE1  3
`define TOCP_C1_EDGE1   1
`define TOCP_C1_LVL1    0
`define TOCP_C1_LVL2    2
// Control 2 bits
`define TOCP_C2_PIN1E   7
`define TOCP_C2_PIN2E   6
`define TOCP_C2_OPM     5
`define TOCP_C2_PWM     4
`define TOCP_C2_CSH     3
`define TOCP_C2_CSL     2
`define TOCP_C2_EDGE2   1
`define TOCP_C2_EXEDG   0
// Status bits
`define TOCP_S_CAP1     7
`define TOCP_S_CMP1     6
`define TOCP_S_CAP2     4
`define TOCP_S_CMP2     3
`define TOCP_CMP_RST    16'h8000
`define TOCP_CNT_RST    16'hfffc
`define TOCP_CTRL_RST   8'h00
`endif

// file: tocp_checker.sv
// Port-level assertions for the compare block
`include "tocp_regs.vh"
module tocp_checker (
   input logic        pclk,             // Clock
   input logic        presetn,          // Reset, low
   input logic        psel,             // Select
   input logic        penable,          // Enable
   input logic        pwrite,           // Direction
   input logic [7:0]  paddr,            // Address
   input logic [31:0] pwdata,           // Write data
   input logic [31:0] prdata,           // Read data
   input logic        pready,           // Ready
   input logic        pslverr,          // Error
   input logic        gpio_out1,        // Port latch 1
   input logic        gpio_out2,        // Port latch 2
   input logic        compare_out_pin1, // Pin 1
   input logic        compare_out_pin2, // Pin 2
   input logic        timer_irq         // Interrupt
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       mask_q;
   logic [7:0] ctrl2_q;
   logic [7:0] oc_q [4];
   wire        oc_hit = paddr >= `TOCP_A_OC1H && paddr <= `TOCP_A_OC2L;
   wire  [7:0] oc_off = paddr - `TOCP_A_OC1H;
   wire  [1:0] oc_i   = oc_off[3:2];
   // Mirrors of written registers, so read data can be judged
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_q  <= 1'b1;
         ctrl2_q <= `TOCP_CTRL_RST;
         oc_q    <= '{8'h80, 8'h00, 8'h80, 8'h00};
      end else if (psel && penable && pready && pwrite) begin
         if (paddr == `TOCP_A_MASK)
            mask_q <= pwdata[0];
         if (paddr == `TOCP_A_CTRL2)
            ctrl2_q <= pwdata[7:0];
         if (oc_hit)
            oc_q[oc_i] <= pwdata[7:0];
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_done;
      psel && penable && pready;
   endsequence
   property p_answer;
      s_setup |=> s_done;
   endproperty
   a_answer: assert property (p_answer) else $error("no ready after setup");
   property p_ready_phase;
      pready |-> psel && penable;
   endproperty
   a_ready_phase: assert property (p_ready_phase) else $error("stray ready");
   property p_readback;
      s_done ##0 (!pwrite && oc_hit) |-> prdata[7:0] == oc_q[oc_i];
   endproperty
   a_readback: assert property (p_readback) else $error("compare value altered");
   property p_refuse;
      s_done ##0 (paddr > `TOCP_A_MASK) |-> pslverr && prdata == 32'h0;
   endproperty
   a_refuse: assert property (p_refuse) else $error("unmapped access accepted");
   property p_accept;
      s_done ##0 (paddr <= `TOCP_A_MASK && paddr[1:0] == 2'b00) |-> !pslverr;
   endproperty
   a_accept: assert property (p_accept) else $error("mapped access refused");
   property p_reset_low;
      disable iff (1'b0) !presetn |-> !compare_out_pin1 && !compare_out_pin2 && !timer_irq;
   endproperty
   a_reset_low: assert property (p_reset_low) else $error("pin high in reset");
   property p_io1;
      (!ctrl2_q[7] && $stable(gpio_out1)) [*3] |-> compare_out_pin1 == gpio_out1;
   endproperty
   a_io1: assert property (p_io1) else $error("pin 1 not port latch");
   property p_io2;
      (!ctrl2_q[6] && $stable(gpio_out2)) [*3] |-> compare_out_pin2 == gpio_out2;
   endproperty
   a_io2: assert property (p_io2) else $error("pin 2 not port latch");
   property p_irq_mask;
      mask_q [*3] |-> !timer_irq;
   endproperty
   a_irq_mask: assert property (p_irq_mask) else $error("irq while masked");
endmodule // tocp_checker

// file: tocp_partner.sv
// Trigger source on the capture pins and a load that times pin 1 pulses
module tocp_partner (
   input  logic pclk,     // Clock
   input  logic pulse_in, // Pin 1 level
   output logic trig1,    // Capture input 1
   output logic trig2,    // Capture input 2
   output logic ext_clk   // External timer clock
);
   timeunit 1ns;
   timeprecision 1ps;
   int run = 0;
   int width = 0;
   initial begin
      trig1 = 1'b0;
      trig2 = 1'b0;
      ext_clk = 1'b0;
   end
   always @(posedge pclk) begin
      run <= pulse_in ? run + 1 : 0;
      if (!pulse_in && run != 0)
         width <= run;
   end
   task automatic set1(input logic v);
      @(posedge pclk);
      trig1 <= v;
   endtask
   task automatic set2(input logic v);
      @(posedge pclk);
      trig2 <= v;
   endtask
   // Two pclk per phase keeps every edge visible to the timer
   task automatic run_ext(input int k);
      repeat (2 * k) begin
         repeat (2) @(posedge pclk);
         ext_clk <= !ext_clk;
      end
   endtask
endmodule // tocp_partner

// file: timer_output_compare_one_pulse_test.sv
// Self-checking bench for the compare block with one pulse mode
`include "tocp_regs.vh"
module timer_output_compare_one_pulse_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int PW = (8'h40 + 5) * 2; // Pulse in pclk at clock/2
   logic        pclk, presetn, psel, penable, pwrite, gpio_out1, gpio_out2;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic        pready, pslverr, compare_out_pin1, compare_out_pin2, timer_irq;
   logic        trig1, trig2, ext_clk;
   int          errors = 0;
   int          samples_checked = 0;
   int          cycles = 0;
   int          n;
   tocp_top dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .capture_in_pin1(trig1), .capture_in_pin2(trig2), .ext_clk_pin(ext_clk),
      .gpio_out1(gpio_out1), .gpio_out2(gpio_out2), .compare_out_pin1(compare_out_pin1),
      .compare_out_pin2(compare_out_pin2), .timer_irq(timer_irq));
   tocp_partner u_far (.pclk(pclk), .pulse_in(compare_out_pin1), .trig1(trig1),
      .trig2(trig2), .ext_clk(ext_clk));
   task automatic give_verdict();
      if (errors == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
         errors++;
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Ends once pready is seen high; if it never is, the bench timeout ends it
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      r = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] r;
      apb(1'b1, a, {24'h0, d}, r);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e,
                     input logic [31:0] m = 32'hffffffff);
      logic [31:0] r;
      apb(1'b0, a, 32'h0, r);
      check(r & m, e);
   endtask
   // Sampled before the edge settles, so rise-to-rise counts are exact
   task automatic till(input bit p2, input logic v, output int c);
      c = 0;
      while ((p2 ? compare_out_pin2 : compare_out_pin1) !== v && c < 400) begin
         @(posedge pclk);
         c++;
      end
      if (c == 400)
         errors++;
   endtask
   task automatic wait3();
      repeat (3) @(posedge pclk);
   endtask
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         errors++;
         give_verdict();
      end
   end
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      gpio_out1 = 1'b1;
      gpio_out2 = 1'b1;
      repeat (3) @(posedge pclk);
      check({compare_out_pin1, compare_out_pin2}, 0);
      presetn <= 1'b1;
      for (int i = 0; i < 4; i++)
         rd(`TOCP_A_OC1H + 8'(4 * i), i[0] ? 8'h00 : 8'h80);
      wr(`TOCP_A_OC2H, 8'h5a);
      rd(`TOCP_A_OC2H, 8'h5a);
      rd(8'h38, 0);
      check(compare_out_pin1, 1);
      wr(`TOCP_A_CTRL1, 8'h05);
      wr(`TOCP_A_CTRL2, 8'hc0);
      wr(`TOCP_A_OC1H, 8'h00);
      wr(`TOCP_A_OC1L, 8'h40);
      wr(`TOCP_A_OC2H, 8'h00);
      wr(`TOCP_A_OC2L, 8'h50);
      wr(`TOCP_A_CNTL, 8'h00);
      till(0, 1, n);
      check(compare_out_pin2, 0);
      till(1, 1, n);
      check(n, 32);
      rd(`TOCP_A_STATUS, 8'h48, 8'h48);
      rd(`TOCP_A_OC1L, 8'h40);
      rd(`TOCP_A_STATUS, 0, 8'h40);
      wr(`TOCP_A_OC1H, 8'h00);
      wr(`TOCP_A_CNTL, 8'h00);
      repeat (160) @(posedge pclk);
      rd(`TOCP_A_STATUS, 0, 8'h40);
      wr(`TOCP_A_OC1L, 8'h40);
      wr(`TOCP_A_CTRL1, 8'h45);
      for (int i = 0; i < 3; i++) begin
         wr(`TOCP_A_MASK, 8'(i == 1));
         wait3();
         check(timer_irq, i != 1);
      end
      rd(`TOCP_A_STATUS, 8'h08, 8'h08);
      rd(`TOCP_A_OC2L, 8'h50);
      wait3();
      check(timer_irq, 0);
      wr(`TOCP_A_CTRL2, 8'h00);
      gpio_out1 <= 1'b0;
      gpio_out2 <= 1'b0;
      wait3();
      check({compare_out_pin1, compare_out_pin2}, 0);
      wr(`TOCP_A_CTRL2, 8'hc0);
      for (int i = 0; i < 3; i++) begin
         wr(`TOCP_A_CTRL1, 8'h08 | 8'(i == 1));
         wait3();
         check(compare_out_pin1, i == 1);
      end
      rd(`TOCP_A_STATUS, 0, 8'h40);
      wr(`TOCP_A_CTRL1, 8'h06);
      wr(`TOCP_A_CTRL2, 8'he0);
      u_far.set1(1'b1);
      till(0, 1, n);
      check(n, 3);
      till(0, 0, n);
      @(posedge pclk);
      check(u_far.width >= PW - 4 && u_far.width <= PW + 4, 1);
      rd(`TOCP_A_STATUS, 8'h80, 8'hc0);
      wr(`TOCP_A_CTRL1, 8'h0f);
      wait3();
      check(compare_out_pin1, 0);
      wr(`TOCP_A_IC1L, 8'h00);
      rd(`TOCP_A_STATUS, 0, 8'h80);
      wr(`TOCP_A_CTRL1, 8'h02);
      u_far.set1(1'b0);
      u_far.set1(1'b1);
      u_far.set2(1'b1);
      u_far.set2(1'b0);
      wait3();
      check(compare_out_pin1, 0);
      // Long enough for the counter to pass both compare values
      repeat (200) @(posedge pclk);
      check({compare_out_pin1, compare_out_pin2}, 1);
      rd(`TOCP_A_STATUS, 8'h98, 8'hd8);
      check(timer_irq, 0);
      wr(`TOCP_A_CTRL1, 8'h82);
      wait3();
      check(timer_irq, 1);
      wr(`TOCP_A_IC1L, 8'h00);
      wr(`TOCP_A_CTRL1, 8'h06);
      wr(`TOCP_A_CTRL2, 8'hf0);
      u_far.set1(1'b0);
      u_far.set1(1'b1);
      wait3();
      check(compare_out_pin1, 0);
      rd(`TOCP_A_STATUS, 0, 8'h80);
      // 64 edges hold a whole number of ticks for every divider
      for (int i = 0; i < 3; i++) begin
         wr(`TOCP_A_CTRL2, 8'(i << 2));
         wr(`TOCP_A_CNTL, 8'h00);
         repeat (63) @(posedge pclk);
         rd(`TOCP_A_CNTL, 32'(64 / (2 << i) - 4));
      end
      wr(`TOCP_A_CTRL2, 8'h0d);
      wr(`TOCP_A_CNTL, 8'h00);
      u_far.run_ext(8);
      rd(`TOCP_A_CNTL, 8'h04);
      u_far.set1(1'b0);
      give_verdict();
   end
endmodule // timer_output_compare_one_pulse_test
bind tocp_top tocp_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .gpio_out1(gpio_out1), .gpio_out2(gpio_out2),
   .compare_out_pin1(compare_out_pin1), .compare_out_pin2(compare_out_pin2),
   .timer_irq(timer_irq));
